// [design/rpcs_pkg.sv]
// Package for the reset pin state and clock select block.
// Holds widths, reset values and cycle counts shared by the design.
package rpcs_pkg;
  // Address bus covers bits 39 down to 4.
  localparam int RPCS_ADDR_HI = 39;
  localparam int RPCS_ADDR_LO = 4;
  localparam int RPCS_ADDR_W = RPCS_ADDR_HI - RPCS_ADDR_LO + 1;
  localparam int RPCS_CMD_W = 4;
  localparam int RPCS_RATIO_W = 4;
  localparam int RPCS_DELAY_W = 3;
  // Command code presented while the bus is driven in reset.
  localparam logic [3:0] RPCS_CMD_NOP = 4'h0;
  // Driven address value in reset is unspecified; zero is used.
  localparam logic [35:0] RPCS_ADDR_RESET = 36'h0_0000_0000;
  localparam logic [3:0] RPCS_RATIO_RESET = 4'h0;
  localparam logic [2:0] RPCS_DELAY_RESET = 3'h0;
  // Settling time for changed configuration straps, in internal cycles.
  localparam int RPCS_CFG_SETTLE_CYC = 20;
  typedef enum logic [1:0] {RPCS_RING, RPCS_EXT} rpcs_src_t;
endpackage : rpcs_pkg

// [design/rpcs_reset_pins.sv]
// Reset-time pin state of the system interface and clock source selection.
// Assumes mclk is the system clock and pin inputs arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module rpcs_reset_pins
  import rpcs_pkg::*;
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // Power and system reset pins.
  input wire logic power_good_in,
  input wire logic sys_reset_n,
  // Bus request and strap pins.
  input wire logic addr_bus_req_in,
  input wire logic [RPCS_RATIO_W-1:0] irq_in,
  input wire logic halt_irq_in,
  input wire logic pwr_fail_irq_in,
  input wire logic mchk_irq_in,
  // Clock source pins.
  input wire logic ring_clk_in,
  input wire logic osc_clk_in_p,
  input wire logic osc_clk_in_n,
  // System interface outputs.
  output logic [RPCS_ADDR_W-1:0] addr_out,
  output logic addr_oe,
  output logic [RPCS_CMD_W-1:0] cmd_out,
  output logic cmd_oe,
  // Weak pull-down request on all pins.
  output logic weak_pulldown,
  // Clock selection and configuration.
  output logic core_clk,
  output logic use_ext_clk,
  output logic [RPCS_RATIO_W-1:0] ratio_out,
  output logic [RPCS_DELAY_W-1:0] delay_out,
  output logic cfg_valid,
  // Quiet outputs during reset.
  output logic srom_clk_out,
  output logic srom_oe_n,
  output logic test_status_out
);

  localparam int SYNC_W = 3 + RPCS_RATIO_W + RPCS_DELAY_W;

  // Three-stage synchronisers for all asynchronous pins.
  logic [SYNC_W-1:0] raw, s1, s2, s3;
  logic [SYNC_W-1:0] next_s1, next_s2, next_s3;
  logic pg, in_reset, req;
  logic [RPCS_RATIO_W-1:0] ratio, next_ratio;
  logic [RPCS_DELAY_W-1:0] delay, next_delay;
  logic [4:0] settle, next_settle;
  logic drive, next_drive;

  assign raw = {power_good_in, sys_reset_n, addr_bus_req_in, irq_in,
                halt_irq_in, pwr_fail_irq_in, mchk_irq_in};

  // A change counts only when the second and third stages agree.
  always_comb begin
    next_s1 = raw;
    next_s2 = s1;
    next_s3 = s2;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (clk_en) begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  // Filtered levels; hold the last agreed value on disagreement.
  logic [SYNC_W-1:0] flt, next_flt;
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      next_flt[i] = (s2[i] == s3[i]) ? s3[i] : flt[i];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flt <= '0;
    end else if (clk_en) begin
      flt <= next_flt;
    end
  end

  assign pg = flt[SYNC_W-1];
  // Missing power-good forces reset internally.
  assign in_reset = !flt[SYNC_W-2] || !pg;
  assign req = flt[SYNC_W-3];

  // Strap capture and bus drive decision.
  always_comb begin
    next_ratio = ratio;
    next_delay = delay;
    next_settle = settle;
    next_drive = drive;
    if (in_reset) begin
      next_drive = !req;
      next_ratio = flt[RPCS_DELAY_W +: RPCS_RATIO_W];
      next_delay = flt[RPCS_DELAY_W-1:0];
      // A strap change restarts the settling count.
      if (next_ratio != ratio || next_delay != delay) begin
        next_settle = 5'(RPCS_CFG_SETTLE_CYC);
      end else if (settle != 5'd0) begin
        next_settle = settle - 5'd1;
      end
    end else begin
      next_drive = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ratio <= RPCS_RATIO_RESET;
      delay <= RPCS_DELAY_RESET;
      settle <= 5'(RPCS_CFG_SETTLE_CYC);
      drive <= 1'b0;
    end else if (clk_en) begin
      ratio <= next_ratio;
      delay <= next_delay;
      settle <= next_settle;
      drive <= next_drive;
    end
  end

  // Output pins; weak pull-down state overrides all drive.
  always_comb begin
    // Float with pull-downs when power is not good.
    weak_pulldown = !pg && in_reset;
    addr_oe = drive && pg && in_reset;
    addr_out = RPCS_ADDR_RESET;
    cmd_oe = drive && pg && in_reset;
    cmd_out = RPCS_CMD_NOP;
    // Quiet serial ROM and test outputs.
    srom_clk_out = 1'b0;
    srom_oe_n = 1'b1;
    test_status_out = 1'b0;
    ratio_out = ratio;
    delay_out = delay;
    cfg_valid = (settle == 5'd0);
    use_ext_clk = pg;
  end

  // Clock mux; glitch-free switching is left to the clock cell
  // downstream; this block itself switches core_clk with a plain mux on pg.
  assign core_clk = pg ? (osc_clk_in_p & ~osc_clk_in_n) : ring_clk_in;

  // Checks; a drive that outlives reset would fight the chipset on the bus.
  // Drive only in reset.
  drive_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
    addr_oe |-> (pg && in_reset))
    else $error("address driven outside reset");
  req_steer_a: assert property (@(posedge mclk) disable iff (!rstn)
    (clk_en && in_reset && pg) |=> (!in_reset || !pg || (addr_oe == !$past(req))))
    else $error("address drive does not follow request");
  cmd_nop_a: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_oe |-> (cmd_out == RPCS_CMD_NOP))
    else $error("command not no-op");
  cmd_steer_a: assert property (@(posedge mclk) disable iff (!rstn)
    (clk_en && in_reset && pg) |=> (!in_reset || !pg || (cmd_oe == !$past(req))))
    else $error("command drive does not follow request");
  ratio_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
    (clk_en && in_reset) |=> (ratio == $past(flt[RPCS_DELAY_W +: RPCS_RATIO_W])))
    else $error("ratio not captured");
  strap_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    (clk_en && !in_reset) |=> ($stable(ratio) && $stable(delay)))
    else $error("straps taken outside reset");
  delay_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
    (clk_en && in_reset) |=> (delay == $past(flt[RPCS_DELAY_W-1:0])))
    else $error("delay not captured");
  settle_load_a: assert property (@(posedge mclk) disable iff (!rstn)
    (clk_en && in_reset && (flt[RPCS_DELAY_W +: RPCS_RATIO_W] != ratio)) |=> !cfg_valid)
    else $error("configuration valid during settling");
  ring_src_a: assert property (@(posedge mclk) disable iff (!rstn)
    !pg |-> !use_ext_clk)
    else $error("external clock without power");
  ring_path_a: assert property (@(posedge mclk) disable iff (!rstn)
    !use_ext_clk |-> (core_clk == ring_clk_in))
    else $error("core not on ring clock");
  ext_src_a: assert property (@(posedge mclk) disable iff (!rstn)
    pg |-> use_ext_clk)
    else $error("ring clock with power");
  ext_sync_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(use_ext_clk) |-> ($past(s2[SYNC_W-1]) && $past(s3[SYNC_W-1])))
    else $error("clock source switched before power good settled");
  osc_path_a: assert property (@(posedge mclk) disable iff (!rstn)
    (use_ext_clk && (osc_clk_in_p != osc_clk_in_n)) |-> (core_clk == osc_clk_in_p))
    else $error("core not on oscillator");
  float_pd_a: assert property (@(posedge mclk) disable iff (!rstn)
    !pg |-> (weak_pulldown && !addr_oe && !cmd_oe))
    else $error("pins not floated");
  quiet_out_a: assert property (@(posedge mclk) disable iff (!rstn)
    in_reset |-> (!srom_clk_out && srom_oe_n && !test_status_out))
    else $error("quiet outputs active");
  // Enable low must hold the filters, the ratio, the settling count and the drive register.
  freeze_state_a: assert property (@(posedge mclk) disable iff (!rstn)
    !clk_en |=> ($stable(flt) && $stable(ratio) && $stable(settle) && $stable(drive)))
    else $error("state moved with enable low");
endmodule // rpcs_reset_pins
`default_nettype wire

// [bench/rpcs_chipset_model.sv]
// Chipset model that drives the power, reset, bus request and strap pins.
// Assumes the bench gives the wanted levels; pins change only after mclk rises.
`timescale 1ns/1ps
`default_nettype none
module rpcs_chipset_model (
  // Clock and wanted levels.
  input wire logic mclk,
  input wire logic pg_want,
  input wire logic sys_rst_want_n,
  input wire logic req_want,
  input wire logic [6:0] strap_want,
  // Pins toward the block.
  output logic power_good_in,
  output logic sys_reset_n,
  output logic addr_bus_req_in,
  output logic [3:0] irq_in,
  output logic [2:0] delay_strap,
  output logic trst_n
);
  // Everything starts quiet: power not good and system reset asserted.
  initial begin
    power_good_in = 1'b0;
    sys_reset_n = 1'b0;
    addr_bus_req_in = 1'b0;
    irq_in = 4'h0;
    delay_strap = 3'h0;
    trst_n = 1'b0;
  end
  // Pins follow the wanted levels one edge later, as a real controller would.
  // Acknowledges stay idle: the model has no acknowledge or fill line to raise.
  always @(posedge mclk) begin
    power_good_in <= pg_want;
    sys_reset_n <= sys_rst_want_n;
    trst_n <= 1'b0;
    addr_bus_req_in <= req_want;
    irq_in <= strap_want[6:3];
    delay_strap <= strap_want[2:0];
  end
endmodule // rpcs_chipset_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the reset pin state and clock select block.
// Assumes the chipset model drives the pins; most scenarios run inside system reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  import rpcs_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, clk_en = 1'b1, ring = 1'b0, osc = 1'b0;
  logic pg_want = 1'b0, req_want = 1'b0, rst_want_n = 1'b0;
  logic [6:0] strap_want = 7'h00;
  wire logic pg, srn, req, trst_n;
  wire logic [3:0] irq;
  wire logic [2:0] dly;
  logic [RPCS_ADDR_W-1:0] addr_out;
  logic [3:0] cmd_out, ratio_out;
  logic [2:0] delay_out;
  logic addr_oe, cmd_oe, weak_pulldown, core_clk, use_ext_clk, cfg_valid, srom_clk_out, srom_oe_n, test_status_out;
  int error_cnt = 0, n_compared = 0;
  // Clocks: the ring and oscillator are unrelated in phase to mclk.
  always #10 mclk = ~mclk;
  always #37 ring = ~ring;
  always #6 osc = ~osc;
  rpcs_chipset_model rpcs_chipset_model_inst (.mclk(mclk), .pg_want(pg_want), .sys_rst_want_n(rst_want_n),
    .req_want(req_want), .strap_want(strap_want), .power_good_in(pg), .sys_reset_n(srn),
    .addr_bus_req_in(req), .irq_in(irq),
    .delay_strap(dly), .trst_n(trst_n));
  rpcs_reset_pins rpcs_reset_pins_inst (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .power_good_in(pg),
    .sys_reset_n(srn), .addr_bus_req_in(req), .irq_in(irq), .halt_irq_in(dly[2]), .pwr_fail_irq_in(dly[1]),
    .mchk_irq_in(dly[0]), .ring_clk_in(ring), .osc_clk_in_p(osc), .osc_clk_in_n(~osc), .addr_out(addr_out),
    .addr_oe(addr_oe), .cmd_out(cmd_out), .cmd_oe(cmd_oe), .weak_pulldown(weak_pulldown), .core_clk(core_clk),
    .use_ext_clk(use_ext_clk), .ratio_out(ratio_out), .delay_out(delay_out), .cfg_valid(cfg_valid),
    .srom_clk_out(srom_clk_out), .srom_oe_n(srom_oe_n), .test_status_out(test_status_out));
  // Waits n rising edges and then half a cycle, plus half a nanosecond so that
  // no clock source toggles in the same time step as the checks.
  task automatic wait_settled(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
    #0.5;
  endtask
  // Power not good: pins float with pull-downs and the ring clock runs the core.
  task automatic pg_low_float();
    wait_settled(10);
    `CHK(weak_pulldown, 1'b1)
    `CHK({addr_oe, cmd_oe}, 2'h0)
    `CHK(use_ext_clk, 1'b0)
    `CHK(core_clk, ring)
    `CHK({srom_clk_out, srom_oe_n, test_status_out}, 3'h2)
    `CHK(trst_n, 1'b0)
  endtask
  // Power good with the bus free: the source switches after the filter and a no-op is driven in the same cycle.
  task automatic pg_high_drive();
    @(posedge mclk);
    pg_want <= 1'b1;
    req_want <= 1'b0;
    wait_settled(4);
    `CHK(use_ext_clk, 1'b0)
    wait_settled(1);
    `CHK(use_ext_clk, 1'b1)
    `CHK(core_clk, osc)
    `CHK(weak_pulldown, 1'b0)
    `CHK({addr_oe, cmd_oe}, 2'h3)
    `CHK(addr_out, RPCS_ADDR_RESET)
    `CHK(cmd_out, RPCS_CMD_NOP)
  endtask
  // The system takes the bus: both pin groups float one edge after the filter, then drive again.
  task automatic bus_request();
    @(posedge mclk);
    req_want <= 1'b1;
    wait_settled(5);
    `CHK({addr_oe, cmd_oe}, 2'h3)
    wait_settled(1);
    `CHK({addr_oe, cmd_oe}, 2'h0)
    @(posedge mclk);
    req_want <= 1'b0;
    wait_settled(10);
    `CHK({addr_oe, cmd_oe}, 2'h3)
  endtask
  // Straps are taken as ratio and delay; valid rises exactly when settling ends.
  task automatic straps();
    @(posedge mclk);
    strap_want <= 7'h55;
    wait_settled(RPCS_CFG_SETTLE_CYC + 5);
    `CHK(ratio_out, 4'hA)
    `CHK(delay_out, 3'h5)
    `CHK(cfg_valid, 1'b0)
    wait_settled(1);
    `CHK(cfg_valid, 1'b1)
  endtask
  // Enable low freezes the straps; they move on once it returns.
  task automatic enable_freeze();
    @(posedge mclk);
    clk_en <= 1'b0;
    strap_want <= 7'h3C;
    wait_settled(10);
    `CHK(ratio_out, 4'hA)
    `CHK(delay_out, 3'h5)
    @(posedge mclk);
    clk_en <= 1'b1;
    wait_settled(6);
    `CHK(ratio_out, 4'h7)
    `CHK(delay_out, 3'h4)
  endtask
  // System reset released: the bus floats and straps are ignored until reset returns.
  task automatic reset_release();
    @(posedge mclk);
    rst_want_n <= 1'b1;
    wait_settled(10);
    `CHK({addr_oe, cmd_oe}, 2'h0)
    @(posedge mclk);
    strap_want <= 7'h55;
    wait_settled(10);
    `CHK(ratio_out, 4'h7)
    `CHK(delay_out, 3'h4)
    @(posedge mclk);
    rst_want_n <= 1'b0;
    wait_settled(10);
    `CHK(ratio_out, 4'hA)
    `CHK({addr_oe, cmd_oe}, 2'h3)
  endtask
  // Block reset in mid-run: state clears, then power good is filtered in again.
  task automatic block_reset();
    @(posedge mclk);
    rstn <= 1'b0;
    wait_settled(1);
    `CHK(ratio_out, RPCS_RATIO_RESET)
    `CHK(cfg_valid, 1'b0)
    `CHK(weak_pulldown, 1'b1)
    @(posedge mclk);
    rstn <= 1'b1;
    wait_settled(3);
    `CHK({use_ext_clk, addr_oe, cmd_oe}, 3'h0)
    wait_settled(1);
    `CHK({use_ext_clk, addr_oe, cmd_oe}, 3'h7)
    wait_settled(6);
    `CHK(ratio_out, 4'hA)
  endtask
  // Closing task: prints the counts and the verdict.
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence after a five-cycle reset.
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    pg_low_float();
    pg_high_drive();
    bus_request();
    straps();
    enable_freeze();
    reset_release();
    block_reset();
    tally_and_finish();
  end
  // Watchdog: the tests need about 130 cycles, so 2000 means a hang.
  initial begin
    repeat (2000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
